// ===== tmw_pkg.sv
// Purpose: shared constants for the eight-bit waveform timer
// Assumes: eight-bit register port, one clock domain
// Notes:   offsets are word indices on the plain register port
package tmw_pkg;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [2:0] A_CTRL  = 3'h0;
  localparam logic [2:0] A_COUNT = 3'h1;
  localparam logic [2:0] A_CMP   = 3'h2;
  localparam logic [2:0] A_FLAG  = 3'h3;
  localparam logic [2:0] A_PIN   = 3'h4;

  // control field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_ACT_LSB  = 2;
  localparam int unsigned CTRL_CS_LSB   = 4;
  localparam int unsigned CTRL_FORCE    = 7;

  // flag and pin field positions
  localparam int unsigned FLAG_OVF = 0;
  localparam int unsigned FLAG_CMP = 1;
  localparam int unsigned PIN_DIR  = 0;
  localparam int unsigned PIN_WAVE = 1;

  // reset values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] CMP_RST   = 8'h00;

  // counter limits
  localparam logic [7:0] MAX_COUNT = 8'hff;
  localparam logic [7:0] BOTTOM    = 8'h00;

  // waveform modes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PHASE  = 2'h1;
  localparam logic [1:0] MODE_CTC    = 2'h2;
  localparam logic [1:0] MODE_FAST   = 2'h3;

  // output actions
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;

  // clock select codes
  localparam logic [2:0] CS_STOP  = 3'h0;
  localparam logic [2:0] CS_D1    = 3'h1;
  localparam logic [2:0] CS_D8    = 3'h2;
  localparam logic [2:0] CS_D64   = 3'h3;
  localparam logic [2:0] CS_D256  = 3'h4;
  localparam logic [2:0] CS_D1024 = 3'h5;

  // prescaler width and division masks
  localparam int unsigned PS_W = 10;
  localparam logic [9:0] PS_M1    = 10'h000;
  localparam logic [9:0] PS_M8    = 10'h007;
  localparam logic [9:0] PS_M64   = 10'h03f;
  localparam logic [9:0] PS_M256  = 10'h0ff;
  localparam logic [9:0] PS_M1024 = 10'h3ff;
endpackage

// ===== tmw_presc_if.sv
// Purpose: carries clock select and timer tick between timer and prescaler
// Assumes: single clock domain
// Notes:   tick is a one-cycle enable
`timescale 1ns/1ps
interface tmw_presc_if;
  logic [2:0] clk_sel;
  logic       tick;
  modport ctrl  (output clk_sel, input tick);
  modport presc (input clk_sel, output tick);
endinterface

// ===== tmw_prescale.sv
// Purpose: divides the i/o clock into the timer clock enable
// Assumes: clock select may change at any time
// Notes:   free-running divider, so a new factor takes effect mid-period
`timescale 1ns/1ps
module tmw_prescale
(
  input  wire logic  clock,
  input  wire logic  arst_n,
  tmw_presc_if.presc ps
);
  logic [tmw_pkg::PS_W-1:0] div_q;
  logic [tmw_pkg::PS_W-1:0] div_d;
  logic [tmw_pkg::PS_W-1:0] mask;
  logic                     run;

  assign div_d = div_q + 10'h001;
  assign run   = (ps.clk_sel >= tmw_pkg::CS_D1) && (ps.clk_sel <= tmw_pkg::CS_D1024);
  assign mask  = (ps.clk_sel == tmw_pkg::CS_D8)    ? tmw_pkg::PS_M8 :
                 (ps.clk_sel == tmw_pkg::CS_D64)   ? tmw_pkg::PS_M64 :
                 (ps.clk_sel == tmw_pkg::CS_D256)  ? tmw_pkg::PS_M256 :
                 (ps.clk_sel == tmw_pkg::CS_D1024) ? tmw_pkg::PS_M1024 :
                                                     tmw_pkg::PS_M1;
  // codes 6 and 7 stop the timer like code 0
  assign ps.tick = run && ((div_q & mask) == mask);

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      div_q <= '0;
    else
      div_q <= div_d;
  end
endmodule

// ===== tmw_timer.sv
// Purpose: eight-bit timer with compare unit and waveform generator
// Assumes: register strobes are one cycle, synchronous to clock
// Notes:   phase-correct mode code counts like normal mode here
`timescale 1ns/1ps
module tmw_timer
(
  input  wire logic [tmw_pkg::ADDR_W-1:0] addr,
  input  wire logic [tmw_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [tmw_pkg::DATA_W-1:0] rdata,
  input  wire logic                       clock,
  input  wire logic                       arst_n,
  input  wire logic                       ovf_ack,
  input  wire logic                       cmp_ack,
  input  wire logic                       port_data,
  output logic                            pin_out,
  output logic                            pin_oe,
  output logic                            overflow_flag,
  output logic                            compare_match_flag
);
  tmw_presc_if ps ();

  logic [7:0] ctrl_q;
  logic [7:0] count_value_q;
  logic [7:0] count_value_d;
  logic [7:0] compare_value_q;
  logic [7:0] compare_value_d;
  logic [7:0] cmp_buf_q;
  logic [7:0] cmp_buf_d;
  logic       ovf_q;
  logic       ovf_d;
  logic       cmf_q;
  logic       cmf_d;
  logic       wave_output_q;
  logic       wave_output_d;
  logic       block_q;
  logic       pin_dir_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  logic [1:0] wave_mode_sel;
  logic [1:0] out_action_sel;
  logic       pin_direction_bit;
  logic       tick;
  logic       wr_ctrl;
  logic       wr_count;
  logic       wr_cmp;
  logic       wr_flag;
  logic       wr_pin;
  logic       force_match_strobe;
  logic       is_pwm;
  logic       is_ctc;
  logic       at_max;
  logic       match;
  logic       match_hit;
  logic       bottom_hit;
  logic       ovf_hit;
  logic       update_pt;
  logic       ovf_clr;
  logic       cmf_clr;

  tmw_prescale u_presc
  (
    .clock  (clock),
    .arst_n (arst_n),
    .ps     (ps.presc)
  );

  // register decode
  assign wr_ctrl  = wr && (addr == tmw_pkg::A_CTRL);
  assign wr_count = wr && (addr == tmw_pkg::A_COUNT);
  assign wr_cmp   = wr && (addr == tmw_pkg::A_CMP);
  assign wr_flag  = wr && (addr == tmw_pkg::A_FLAG);
  assign wr_pin   = wr && (addr == tmw_pkg::A_PIN);

  // force strobe is never stored; only honoured outside pwm
  assign force_match_strobe = wr_ctrl && wdata[tmw_pkg::CTRL_FORCE];

  assign wave_mode_sel     = ctrl_q[tmw_pkg::CTRL_MODE_LSB +: 2];
  assign out_action_sel    = ctrl_q[tmw_pkg::CTRL_ACT_LSB +: 2];
  assign pin_direction_bit = pin_dir_q;
  assign ps.clk_sel        = ctrl_q[tmw_pkg::CTRL_CS_LSB +: 3];
  assign tick              = ps.tick;

  assign is_pwm = (wave_mode_sel == tmw_pkg::MODE_FAST);
  assign is_ctc = (wave_mode_sel == tmw_pkg::MODE_CTC);
  assign at_max = (count_value_q == tmw_pkg::MAX_COUNT);

  // a count write masks the comparator for one timer clock
  assign match      = (count_value_q == compare_value_q) && !block_q;
  assign match_hit  = tick && match;
  assign bottom_hit = tick && at_max && is_pwm;
  assign ovf_hit    = tick && at_max && !wr_count;
  assign update_pt  = tick && at_max;

  // the count sequence depends on mode only, never on the action
  always_comb
  begin
    count_value_d = count_value_q;
    if (wr_count)
      count_value_d = wdata;
    else if (tick)
    begin
      if (is_ctc && match)
        count_value_d = tmw_pkg::BOTTOM;
      else
        count_value_d = count_value_q + 8'h01;
    end
  end

  // in ctc a top written below the count is missed until the wrap
  always_comb
  begin
    compare_value_d = compare_value_q;
    cmp_buf_d       = cmp_buf_q;
    if (wr_cmp)
      cmp_buf_d = wdata;
    if (!is_pwm)
    begin
      if (wr_cmp)
        compare_value_d = wdata;
    end
    else if (update_pt)
      compare_value_d = wr_cmp ? wdata : cmp_buf_q;
  end

  // hardware set wins over a same-cycle clear
  assign ovf_clr = ovf_ack || (wr_flag && wdata[tmw_pkg::FLAG_OVF]);
  assign cmf_clr = cmp_ack || (wr_flag && wdata[tmw_pkg::FLAG_CMP]);
  assign ovf_d   = ovf_hit || (ovf_q && !ovf_clr);
  assign cmf_d   = match_hit || (cmf_q && !cmf_clr);

  // bottom is evaluated last so compare at max gives a steady level
  always_comb
  begin
    wave_output_d = wave_output_q;
    if (!is_pwm)
    begin
      if (match_hit || force_match_strobe)
      begin
        unique case (out_action_sel)
          tmw_pkg::ACT_TOGGLE: wave_output_d = !wave_output_q;
          tmw_pkg::ACT_CLEAR:  wave_output_d = 1'b0;
          tmw_pkg::ACT_SET:    wave_output_d = 1'b1;
          tmw_pkg::ACT_NONE:   wave_output_d = wave_output_q;
        endcase
      end
    end
    else
    begin
      if (match_hit && (out_action_sel == tmw_pkg::ACT_CLEAR))
        wave_output_d = 1'b0;
      if (match_hit && (out_action_sel == tmw_pkg::ACT_SET))
        wave_output_d = 1'b1;
      if (bottom_hit && (out_action_sel == tmw_pkg::ACT_CLEAR))
        wave_output_d = 1'b1;
      if (bottom_hit && (out_action_sel == tmw_pkg::ACT_SET))
        wave_output_d = 1'b0;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (rd)
    begin
      unique case (addr)
        tmw_pkg::A_CTRL:  rdata_d = {1'b0, ctrl_q[6:0]};
        tmw_pkg::A_COUNT: rdata_d = count_value_q;
        tmw_pkg::A_CMP:   rdata_d = is_pwm ? cmp_buf_q : compare_value_q;
        tmw_pkg::A_FLAG:  rdata_d = {6'h00, cmf_q, ovf_q};
        tmw_pkg::A_PIN:   rdata_d = {6'h00, wave_output_q, pin_dir_q};
        default:          rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_q          <= tmw_pkg::CTRL_RST;
      count_value_q   <= tmw_pkg::COUNT_RST;
      compare_value_q <= tmw_pkg::CMP_RST;
      cmp_buf_q       <= tmw_pkg::CMP_RST;
      pin_dir_q       <= 1'b0;
      rdata_q         <= 8'h00;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= {1'b0, wdata[6:0]};
      if (wr_pin)
        pin_dir_q <= wdata[tmw_pkg::PIN_DIR];
      count_value_q   <= count_value_d;
      compare_value_q <= compare_value_d;
      cmp_buf_q       <= cmp_buf_d;
      rdata_q         <= rdata_d;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ovf_q         <= 1'b0;
      cmf_q         <= 1'b0;
      wave_output_q <= 1'b0;
      block_q       <= 1'b0;
    end
    else
    begin
      ovf_q         <= ovf_d;
      cmf_q         <= cmf_d;
      wave_output_q <= wave_output_d;
      // the block lasts until the next timer clock has gone by
      block_q       <= wr_count || (block_q && !tick);
    end
  end

  assign rdata              = rdata_q;
  assign overflow_flag      = ovf_q;
  assign compare_match_flag = cmf_q;
  // normal mode waves cost the cpu an interrupt per edge; not blocked here
  assign pin_out = (out_action_sel != tmw_pkg::ACT_NONE) ? wave_output_q : port_data;
  assign pin_oe  = pin_direction_bit;

  ovf_set_a: assert property (@(posedge clock) disable iff (!arst_n)
    (tick && at_max && !wr_count) |=> overflow_flag)
    else $error("overflow flag not set at wrap");

  norm_wrap_a: assert property (@(posedge clock) disable iff (!arst_n)
    (wave_mode_sel == tmw_pkg::MODE_NORMAL && tick && at_max && !wr_count)
      |=> (count_value_q == tmw_pkg::BOTTOM))
    else $error("normal mode did not wrap to zero");

  ctc_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
    (is_ctc && tick && match && !wr_count && !wr_ctrl) |=> (count_value_q == tmw_pkg::BOTTOM))
    else $error("ctc count not cleared on match");

  cmp_flag_a: assert property (@(posedge clock) disable iff (!arst_n)
    (tick && match) |=> compare_match_flag)
    else $error("compare flag not set on match");

  write_block_a: assert property (@(posedge clock) disable iff (!arst_n)
    wr_count |=> !match)
    else $error("match not blocked after count write");

  ctc_toggle_a: assert property (@(posedge clock) disable iff (!arst_n)
    (is_ctc && out_action_sel == tmw_pkg::ACT_TOGGLE && tick && match && !wr_ctrl)
      |=> (wave_output_q != $past(wave_output_q)))
    else $error("ctc toggle missed");

  pwm_bottom_a: assert property (@(posedge clock) disable iff (!arst_n)
    (is_pwm && out_action_sel == tmw_pkg::ACT_CLEAR && tick && at_max && !wr_ctrl)
      |=> wave_output_q)
    else $error("fast pwm did not set at bottom");

  pin_hide_a: assert property (@(posedge clock) disable iff (!arst_n)
    (wr_pin && !wdata[tmw_pkg::PIN_DIR]) |=> !pin_oe)
    else $error("pin driven while direction is input");

  buf_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    (is_pwm && !update_pt && !wr_ctrl) |=> $stable(compare_value_q))
    else $error("pwm compare changed outside update point");

  no_tick_a: assert property (@(posedge clock) disable iff (!arst_n)
    (!tick && !wr_count) |=> ($stable(count_value_q) && !$rose(overflow_flag)))
    else $error("counter moved without timer clock");

  cnt_write_a: assert property (@(posedge clock) disable iff (!arst_n)
    wr_count |=> (count_value_q == $past(wdata)))
    else $error("count write did not land");

  ovf_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
    (ovf_ack && !ovf_hit) |=> !overflow_flag)
    else $error("overflow flag not cleared by service");

  cmp_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
    (cmp_ack && !match_hit) |=> !compare_match_flag)
    else $error("compare flag not cleared by service");

  cmp_direct_a: assert property (@(posedge clock) disable iff (!arst_n)
    (!is_pwm && wr_cmp) |=> (compare_value_q == $past(wdata)))
    else $error("non-pwm compare write not direct");

  pwm_update_a: assert property (@(posedge clock) disable iff (!arst_n)
    (is_pwm && update_pt && !wr_cmp) |=> (compare_value_q == $past(cmp_buf_q)))
    else $error("pwm buffer not moved at update point");

  pwm_wrap_a: assert property (@(posedge clock) disable iff (!arst_n)
    (is_pwm && tick && at_max && !wr_count) |=> (count_value_q == tmw_pkg::BOTTOM))
    else $error("fast pwm did not restart from bottom");

  act_none_a: assert property (@(posedge clock) disable iff (!arst_n)
    (out_action_sel == tmw_pkg::ACT_NONE) |=> $stable(wave_output_q))
    else $error("wave bit moved with no output action");

  pwm_match_a: assert property (@(posedge clock) disable iff (!arst_n)
    (is_pwm && out_action_sel == tmw_pkg::ACT_SET && match_hit && !at_max) |=> wave_output_q)
    else $error("inverted pwm did not set on match");

  pwm_top_a: assert property (@(posedge clock) disable iff (!arst_n)
    (is_pwm && out_action_sel == tmw_pkg::ACT_CLEAR && compare_value_q == tmw_pkg::MAX_COUNT
      && wave_output_q) |=> wave_output_q)
    else $error("fast pwm at max compare not steady");
endmodule

// ===== tmw_load.sv
// Purpose: external load on the compare output pin
// Assumes: load has a pull-down, so a released pin reads low
// Notes:   counts high cycles at the pad for duty measurement
`timescale 1ns/1ps
module tmw_load
(
  input  wire logic        clock,
  input  wire logic        clr,
  input  wire logic        pin_out,
  input  wire logic        pin_oe,
  output logic             pad,
  output logic [15:0]      high_cnt
);
  // released pin falls to the pull-down, never keeps the wave
  assign pad = pin_oe ? pin_out : 1'b0;
  always_ff @(posedge clock)
  begin
    high_cnt <= clr ? 16'h0000 : high_cnt + {15'h0000, pad};
  end
endmodule

// ===== tmw_timer_tb_top.sv
// Purpose: self-checking bench for the waveform timer
// Assumes: exact count reads are made with the timer stopped
// Notes:   pwm duty is measured at the load, not at the pin
`timescale 1ns/1ps
module tmw_timer_tb_top;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata, v, cv;
  logic        clock, arst_n, wr, rd, ovf_ack, cmp_ack, port_data;
  logic        pin_out, pin_oe, overflow_flag, compare_match_flag;
  logic        pad, load_clr, prev;
  logic [15:0] high_cnt;
  int          bad_count, tests_run, cyc, n, last, e;
  int          divs[8] = '{0, 1, 8, 64, 256, 1024, 0, 0};

  tmw_timer dut_u (.addr, .wdata, .wr, .rd, .rdata, .clock, .arst_n, .ovf_ack, .cmp_ack,
    .port_data, .pin_out, .pin_oe, .overflow_flag, .compare_match_flag);
  tmw_load load_u (.clock, .clr(load_clr), .pin_out, .pin_oe, .pad, .high_cnt);

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // hang guard, well above the longest test sequence
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      bad_count++;
      $display("[ERR] run length exp below %0d got %0d", 60000, cyc);
      complete_run();
    end
  end

  task automatic ck(input string nm, input logic [15:0] ex, input logic [15:0] got);
    tests_run++;
    if (got !== ex)
    begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, ex, got);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic acks();
    @(posedge clock);
    ovf_ack <= 1'b1;
    cmp_ack <= 1'b1;
    @(posedge clock);
    ovf_ack <= 1'b0;
    cmp_ack <= 1'b0;
    #1 ck("flags after ack", 16'h0000, {overflow_flag, compare_match_flag});
  endtask

  function automatic logic [7:0] ctl(logic [1:0] m, logic [1:0] a, logic [2:0] s);
    return {1'b0, s, a, m};
  endfunction

  // high cycles in 512 timer clocks: clear action is high from bottom through the match tick
  function automatic logic [15:0] pwm_hi(logic [1:0] a, logic [7:0] c);
    logic [15:0] h;
    h = 16'h0002 * ({8'h00, c} + 16'h0001);
    return (a == tmw_pkg::ACT_CLEAR) ? h : 16'h0200 - h;
  endfunction

  initial
  begin
    {addr, wdata, wr, rd, ovf_ack, cmp_ack, load_clr} = '0;
    {bad_count, tests_run, cyc} = '0;
    v = 8'($urandom(32'h2f9e));
    port_data = v[0];
    arst_n = 1'b0;
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    #1 ck("reset pins", {14'h0000, port_data, 1'b0}, {14'h0000, pin_out, pin_oe});
    for (int a = 0; a < 8; a++)
    begin
      rd_reg(3'(a), v);
      ck("reset read", 16'h0000, {8'h00, v});
    end
    wr_reg(tmw_pkg::A_CTRL, 8'h80);
    wr_reg(3'h6, 8'hff);
    rd_reg(tmw_pkg::A_CTRL, v);
    ck("force reads zero", 16'h0000, {8'h00, v});
    rd_reg(3'h6, v);
    ck("unmapped read", 16'h0000, {8'h00, v});
    $display("test reset done");

    for (int t = 0; t < 4; t++)
    begin
      cv = 8'hf0 | 8'($urandom_range(15, 0));
      wr_reg(tmw_pkg::A_COUNT, cv);
      acks();
      wr_reg(tmw_pkg::A_CTRL,
        ctl(tmw_pkg::MODE_NORMAL, tmw_pkg::ACT_NONE, tmw_pkg::CS_D1));
      repeat (8) @(posedge clock);
      wr_reg(tmw_pkg::A_CTRL, 8'h00);
      rd_reg(tmw_pkg::A_COUNT, v);
      n = int'(8'(v - cv));
      ck("wrap step", 16'h0001, {15'h0000, n >= 8 && n <= 12});
      ck("overflow at zero", {15'h0000, v < cv}, {15'h0000, overflow_flag});
    end
    wr_reg(tmw_pkg::A_FLAG, 8'h01);
    #1 ck("flag write clear", 16'h0000, {15'h0000, overflow_flag});
    $display("test normal done");

    for (int k = 0; k < 8; k++)
    begin
      wr_reg(tmw_pkg::A_COUNT, 8'h00);
      wr_reg(tmw_pkg::A_CTRL, ctl(tmw_pkg::MODE_NORMAL, tmw_pkg::ACT_NONE, 3'(k)));
      repeat (divs[k] == 0 ? 64 : 4 * divs[k]) @(posedge clock);
      wr_reg(tmw_pkg::A_CTRL, 8'h00);
      rd_reg(tmw_pkg::A_COUNT, v);
      e = divs[k] == 0 ? 0 : (4 * divs[k] + 2) / divs[k];
      if (divs[k] == 0)
        ck("stopped count", 16'h0000, {8'h00, v});
      else
        ck("prescale ticks", 16'h0001, {15'h0000, int'(v) >= e - 1 && int'(v) <= e + 1});
    end
    $display("test prescale done");

    wr_reg(tmw_pkg::A_PIN, 8'h01);
    for (int t = 0; t < 5; t++)
    begin
      n = t == 0 ? 0 : $urandom_range(6, 1);
      e = t[0] ? 8 : 1;
      wr_reg(tmw_pkg::A_CTRL, 8'h00);
      wr_reg(tmw_pkg::A_CMP, 8'(n));
      // the write masks the first tick, so start at max and let it wrap
      wr_reg(tmw_pkg::A_COUNT, 8'hff);
      acks();
      wr_reg(tmw_pkg::A_CTRL, ctl(tmw_pkg::MODE_CTC, tmw_pkg::ACT_TOGGLE,
        t[0] ? tmw_pkg::CS_D8 : tmw_pkg::CS_D1));
      repeat (80) @(posedge clock);
      #1 ck("ctc match flag", 16'h0001, {15'h0000, compare_match_flag});
      prev = pin_out;
      last = -1;
      for (int i = 0; i < 200; i++)
      begin
        @(posedge clock);
        #1 ck("pad follows wave", {15'h0000, pin_out}, {15'h0000, pad});
        if (pin_out !== prev)
        begin
          if (last >= 0)
            ck("toggle gap", 16'(e * (n + 1)), 16'(i - last));
          last = i;
        end
        prev = pin_out;
      end
      ck("toggles seen", 16'h0001, {15'h0000, last >= 0});
    end
    wr_reg(tmw_pkg::A_CTRL, 8'h00);
    rd_reg(tmw_pkg::A_COUNT, v);
    ck("ctc count bounded", 16'h0001, {15'h0000, v <= 8'h06});
    $display("test ctc done");

    wr_reg(tmw_pkg::A_CTRL, ctl(tmw_pkg::MODE_CTC, tmw_pkg::ACT_NONE, tmw_pkg::CS_STOP));
    wr_reg(tmw_pkg::A_CMP, 8'h20);
    wr_reg(tmw_pkg::A_COUNT, 8'h30);
    acks();
    wr_reg(tmw_pkg::A_CTRL, ctl(tmw_pkg::MODE_CTC, tmw_pkg::ACT_NONE, tmw_pkg::CS_D1));
    for (n = 0; overflow_flag !== 1'b1 && n < 300; n++) @(posedge clock) #1;
    ck("missed match wraps", 16'h0001, {15'h0000, overflow_flag});
    ck("no early match", 16'h0000, {15'h0000, compare_match_flag});
    for (n = 0; compare_match_flag !== 1'b1 && n < 64; n++) @(posedge clock) #1;
    ck("match after wrap", 16'h0001, {15'h0000, compare_match_flag});
    wr_reg(tmw_pkg::A_CTRL, ctl(tmw_pkg::MODE_CTC, tmw_pkg::ACT_NONE, tmw_pkg::CS_STOP));
    wr_reg(tmw_pkg::A_CMP, 8'h03);
    wr_reg(tmw_pkg::A_COUNT, 8'h03);
    acks();
    wr_reg(tmw_pkg::A_CTRL, ctl(tmw_pkg::MODE_CTC, tmw_pkg::ACT_NONE, tmw_pkg::CS_D1));
    repeat (20) @(posedge clock);
    wr_reg(tmw_pkg::A_CTRL, 8'h00);
    rd_reg(tmw_pkg::A_COUNT, v);
    ck("blocked match", 16'h0001, {15'h0000, !compare_match_flag && v >= 8'h10});
    $display("test missed match done");

    for (int t = 0; t < 8; t++)
    begin
      cv = t < 2 ? 8'h00 : t < 4 ? 8'hff : 8'($urandom_range(254, 1));
      v = t[0] ? tmw_pkg::ACT_SET : tmw_pkg::ACT_CLEAR;
      wr_reg(tmw_pkg::A_CTRL, ctl(tmw_pkg::MODE_FAST, v[1:0], tmw_pkg::CS_D1));
      wr_reg(tmw_pkg::A_CMP, cv);
      rd_reg(tmw_pkg::A_CMP, v);
      ck("pwm compare buffer", {8'h00, cv}, {8'h00, v});
      repeat (300) @(posedge clock);
      load_clr <= 1'b1;
      @(posedge clock);
      load_clr <= 1'b0;
      repeat (512) @(posedge clock);
      #1 ck("pwm high cycles", pwm_hi(t[0] ? tmw_pkg::ACT_SET : tmw_pkg::ACT_CLEAR, cv),
        high_cnt);
    end
    $display("test fast pwm done");

    wr_reg(tmw_pkg::A_CTRL, ctl(tmw_pkg::MODE_NORMAL, tmw_pkg::ACT_NONE, tmw_pkg::CS_D1));
    repeat (8)
    begin
      @(posedge clock);
      port_data <= 1'($urandom());
      #1 ck("port function", {15'h0000, port_data}, {15'h0000, pin_out});
    end
    // the strobe uses the action already held, so set it first
    wr_reg(tmw_pkg::A_CTRL, ctl(tmw_pkg::MODE_NORMAL, tmw_pkg::ACT_SET, tmw_pkg::CS_STOP));
    wr_reg(tmw_pkg::A_CTRL, 8'h80 | ctl(tmw_pkg::MODE_NORMAL, tmw_pkg::ACT_SET, 3'h0));
    rd_reg(tmw_pkg::A_PIN, v);
    ck("forced set", 16'h0003, {8'h00, v});
    wr_reg(tmw_pkg::A_CTRL, ctl(tmw_pkg::MODE_NORMAL, tmw_pkg::ACT_CLEAR, tmw_pkg::CS_STOP));
    wr_reg(tmw_pkg::A_CTRL, 8'h80 | ctl(tmw_pkg::MODE_NORMAL, tmw_pkg::ACT_CLEAR, 3'h0));
    rd_reg(tmw_pkg::A_PIN, v);
    ck("forced clear", 16'h0001, {8'h00, v});
    wr_reg(tmw_pkg::A_PIN, 8'h00);
    #1 ck("pin released", 16'h0000, {14'h0000, pin_oe, pad});
    $display("test pin done");
    complete_run();
  end
endmodule
